// ---- core/pcr_clk_div.sv ----
// clock-enable divider: one tick every divisor pclk cycles
// assumes divisor is stable for a period; zero stops the ticks
`timescale 1ns/1ps
`default_nettype none
module pcr_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  pcr_div_if.div dif
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } pcr_div_t;
  pcr_div_t div_ff;
  pcr_div_t nxt_div;

  // ==========================================================
  // counter; a zero divisor parks it so the domain stops cleanly
  always_comb begin
    nxt_div = div_ff;
    nxt_div.tick = 1'b0;
    if (dif.divisor == 10'h000) begin
      nxt_div.cnt = 10'h000;
    end else if (div_ff.cnt >= dif.divisor - 10'h001) begin
      nxt_div.cnt = 10'h000;
      nxt_div.tick = 1'b1;
    end else begin
      nxt_div.cnt = div_ff.cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign dif.tick = div_ff.tick;
endmodule
`default_nettype wire

// ---- core/pcr_ctrl.sv ----
// power, clock and reset control block with an apb register port
// assumes peripherals obey the sleep/demand handshake and that the
// system reset arrives on presetn; standby reset is separate
//
// Function
// - sleep request bits command each block to sleep; read/write, reset zero
// - unassigned sleep request bits read back what was last written
// - clock demand bits are read-only live status; unassigned read zero
// - writing one to a reset pulse bit resets that peripheral once
// - reset pulses are ignored while locked; unlock pattern opens them
// - immediate bit lets heavy sleep start before pll lock
// - global sleep forces all requests; sleep after wfi with no demand
// - global sleep bit clears when the processor takes an interrupt
// - mode bit picks light sleep (pll on) or heavy (pll off)
// - wake is instant; heavy sleep waits at most 3 ms for relock
// - processor clock is the source divided by an 8-bit divisor
// - slow clock divides by a 10-bit value; zero stops it
// - pll lock flag is read-only live status of the pll_locked input, not reset
// - status shows host link and low frequency clock presence
// - watchdog flag is write-one-clear and survives system reset
// - system reset flag resets to one; a set beats a clear
// - backup rail reset flag; set beats a clearing write
// - standby rail flag resets to one only on standby reset
// - live platform reset and power good levels are readable
// - select bit picks legacy pin or link platform reset
// - firmware bit drives the power ok output, resets to one
// - writing one to soft reset bit requests system reset
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pcr_ctrl #(
  parameter int unsigned RELOCK_CYCLES = pcr_pkg::RELOCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby_rail_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [4:0][31:0] blk_sleep_req,
  input wire logic [4:0][31:0] blk_clk_demand,
  output logic [4:0][31:0] periph_reset,
  input wire logic cpu_wfi,
  input wire logic cpu_irq_vector,
  input wire logic wake_event,
  input wire logic pll_locked,
  output logic pll_enable,
  output logic main_clk_gate,
  output logic relock_pending,
  output logic cpu_clk_en,
  output logic slow_clk_en,
  input wire logic host_link_clock_seen,
  input wire logic low_freq_input_seen,
  input wire logic watchdog_event,
  input wire logic backup_reset_event,
  input wire logic legacy_reset_n,
  input wire logic link_platform_reset_n,
  output logic platform_reset_n,
  input wire logic main_power_good,
  output logic power_ok_out,
  output logic software_system_reset
);
  typedef struct packed {
    logic [4:0][31:0] sleep_en;
    logic [4:0][31:0] rst_pulse;
    logic sleep_imm;
    logic sleep_all;
    logic sleep_test;
    logic sleep_mode;
    logic [7:0] cpu_div;
    logic [9:0] slow_div;
    logic sys_seen;
    logic backup_seen;
    logic host_sel;
    logic power_ok_drive;
    logic soft_rst;
    logic [31:0] lock_val;
    logic locked;
    pcr_pkg::pcr_state_t state;
    logic [18:0] relock_cnt;
    logic [31:0] rdata;
  } pcr_regs_t;

  // flags kept alive across system reset
  typedef struct packed {
    logic watchdog_fired_flag;
    logic standby_reset_seen;
  } pcr_stby_t;

  pcr_regs_t st_ff;
  pcr_regs_t nxt_st;
  pcr_stby_t sb_ff;
  pcr_stby_t nxt_sb;
  pcr_div_if cpu_dif ();
  pcr_div_if slow_dif ();
  logic wr;
  logic rd_setup;
  logic sleep_ok;
  logic no_demand;
  logic [3:0] hit_req;
  logic [3:0] hit_dem;
  logic [3:0] hit_pls;
  logic mapped;
  logic [31:0] rd_val;

  // ==========================================================
  // address decode for the five-word banks: {hit, index}
  function automatic logic [3:0] bank_hit(input logic [11:0] a,
                                          input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    bank_hit = {(a >= base) && (d < pcr_pkg::BANK_SPAN) &&
                (a[1:0] == 2'b00), d[4:2]};
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit_req = bank_hit(paddr, pcr_pkg::OFF_SLEEP_REQ);
  assign hit_dem = bank_hit(paddr, pcr_pkg::OFF_CLK_DEM);
  assign hit_pls = bank_hit(paddr, pcr_pkg::OFF_RST_PULSE);
  assign no_demand = ((blk_clk_demand & pcr_pkg::DEMAND_MASK) == '0);
  // heavy sleep may start unlocked only with the immediate bit
  assign sleep_ok = pll_locked || (st_ff.sleep_imm && st_ff.sleep_mode);
  assign platform_reset_n = st_ff.host_sel ? legacy_reset_n
                                           : link_platform_reset_n;

  // ==========================================================
  // read mux; data is captured in the setup cycle so that the
  // access cycle answers with zero wait states
  always_comb begin
    rd_val = 32'h00000000;
    mapped = 1'b1;
    if (hit_req[3]) begin
      rd_val = st_ff.sleep_en[hit_req[2:0]];
    end else if (hit_dem[3]) begin
      rd_val = blk_clk_demand[hit_dem[2:0]] &
               pcr_pkg::DEMAND_MASK[hit_dem[2:0]];
    end else if (hit_pls[3]) begin
      rd_val = 32'h00000000;
    end else begin
      unique case (paddr)
        pcr_pkg::OFF_SLEEP_CTL: begin
          rd_val[pcr_pkg::SC_IMM] = st_ff.sleep_imm;
          rd_val[pcr_pkg::SC_ALL] = st_ff.sleep_all;
          rd_val[pcr_pkg::SC_TEST] = st_ff.sleep_test;
          rd_val[pcr_pkg::SC_MODE] = st_ff.sleep_mode;
        end
        pcr_pkg::OFF_CPU_CLK: rd_val[7:0] = st_ff.cpu_div;
        pcr_pkg::OFF_SLOW_CLK: rd_val[9:0] = st_ff.slow_div;
        pcr_pkg::OFF_OSC_STAT: rd_val[pcr_pkg::OS_LOCK] = pll_locked;
        pcr_pkg::OFF_PWR_STAT: begin
          rd_val[pcr_pkg::PS_LINK_CLK] = host_link_clock_seen;
          rd_val[pcr_pkg::PS_LF_CLK] = low_freq_input_seen;
          rd_val[pcr_pkg::PS_WDT] = sb_ff.watchdog_fired_flag;
          rd_val[pcr_pkg::PS_SYS] = st_ff.sys_seen;
          rd_val[pcr_pkg::PS_BACKUP] = st_ff.backup_seen;
          rd_val[pcr_pkg::PS_STBY] = sb_ff.standby_reset_seen;
          rd_val[pcr_pkg::PS_PLT] = platform_reset_n;
          rd_val[pcr_pkg::PS_PWRGD] = main_power_good;
        end
        pcr_pkg::OFF_PWR_CTL: begin
          rd_val[pcr_pkg::PC_SEL] = st_ff.host_sel;
          rd_val[pcr_pkg::PC_POWER_OK_OUT] = st_ff.power_ok_drive;
        end
        pcr_pkg::OFF_SYS_RST: rd_val = 32'h00000000;
        pcr_pkg::OFF_RST_LOCK: rd_val = st_ff.lock_val;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // next state of every system-reset register and of the sleep sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_pulse = '0;
    nxt_st.soft_rst = 1'b0;
    if (rd_setup) begin
      nxt_st.rdata = rd_val;
    end
    if (wr && hit_req[3]) begin
      nxt_st.sleep_en[hit_req[2:0]] = pwdata;
    end
    if (wr && hit_pls[3] && !st_ff.locked) begin
      nxt_st.rst_pulse[hit_pls[2:0]] = pwdata;
    end
    if (wr && paddr == pcr_pkg::OFF_SLEEP_CTL) begin
      nxt_st.sleep_imm = pwdata[pcr_pkg::SC_IMM];
      nxt_st.sleep_all = pwdata[pcr_pkg::SC_ALL];
      nxt_st.sleep_test = pwdata[pcr_pkg::SC_TEST];
      nxt_st.sleep_mode = pwdata[pcr_pkg::SC_MODE];
    end
    // taking an interrupt cancels a pending global sleep
    if (cpu_irq_vector) begin
      nxt_st.sleep_all = 1'b0;
    end
    if (wr && paddr == pcr_pkg::OFF_CPU_CLK) begin
      nxt_st.cpu_div = pwdata[7:0];
    end
    if (wr && paddr == pcr_pkg::OFF_SLOW_CLK) begin
      nxt_st.slow_div = pwdata[9:0];
    end
    // write-one-clear flags; a new event in the same cycle wins
    if (wr && paddr == pcr_pkg::OFF_PWR_STAT) begin
      if (pwdata[pcr_pkg::PS_SYS]) nxt_st.sys_seen = 1'b0;
      if (pwdata[pcr_pkg::PS_BACKUP]) nxt_st.backup_seen = 1'b0;
    end
    if (backup_reset_event) begin
      nxt_st.backup_seen = 1'b1;
    end
    if (st_ff.soft_rst) begin
      nxt_st.sys_seen = 1'b1;
    end
    if (wr && paddr == pcr_pkg::OFF_PWR_CTL) begin
      nxt_st.host_sel = pwdata[pcr_pkg::PC_SEL];
      nxt_st.power_ok_drive = pwdata[pcr_pkg::PC_POWER_OK_OUT];
    end
    if (wr && paddr == pcr_pkg::OFF_SYS_RST && pwdata[pcr_pkg::SR_SOFT]) begin
      nxt_st.soft_rst = 1'b1;
    end
    // any value is stored; only the two patterns move the lock
    if (wr && paddr == pcr_pkg::OFF_RST_LOCK) begin
      nxt_st.lock_val = pwdata;
      if (pwdata == pcr_pkg::LOCK_PAT) nxt_st.locked = 1'b1;
      if (pwdata == pcr_pkg::UNLOCK_PAT) nxt_st.locked = 1'b0;
    end
    // sleep sequencer: run -> sleep -> (relock) -> run
    unique case (st_ff.state)
      pcr_pkg::PCR_RUN: begin
        if ((&blk_sleep_req) && cpu_wfi && no_demand && sleep_ok) begin
          nxt_st.state = pcr_pkg::PCR_SLEEP;
        end
      end
      pcr_pkg::PCR_SLEEP: begin
        nxt_st.relock_cnt = 19'h00000;
        if (wake_event) begin
          nxt_st.state = st_ff.sleep_mode ? pcr_pkg::PCR_RELOCK
                                          : pcr_pkg::PCR_RUN;
        end
      end
      pcr_pkg::PCR_RELOCK: begin
        // clock already runs; this only bounds the wait for lock
        nxt_st.relock_cnt = st_ff.relock_cnt + 19'h00001;
        if (pll_locked ||
            st_ff.relock_cnt >= 19'(RELOCK_CYCLES - 1)) begin
          nxt_st.state = pcr_pkg::PCR_RUN;
        end
      end
      default: nxt_st.state = pcr_pkg::PCR_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.cpu_div <= pcr_pkg::CPU_DIV_RST;
      st_ff.slow_div <= pcr_pkg::SLOW_DIV_RST;
      st_ff.sys_seen <= 1'b1;
      st_ff.host_sel <= 1'b1;
      st_ff.power_ok_drive <= 1'b1;
      st_ff.lock_val <= pcr_pkg::LOCK_PAT;
      st_ff.locked <= 1'b1;
      st_ff.state <= pcr_pkg::PCR_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // standby-domain flags: untouched by the system reset
  always_comb begin
    nxt_sb = sb_ff;
    if (wr && paddr == pcr_pkg::OFF_PWR_STAT) begin
      if (pwdata[pcr_pkg::PS_WDT]) nxt_sb.watchdog_fired_flag = 1'b0;
      if (pwdata[pcr_pkg::PS_STBY]) nxt_sb.standby_reset_seen = 1'b0;
    end
    if (watchdog_event) begin
      nxt_sb.watchdog_fired_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge standby_rail_resetn) begin
    if (!standby_rail_resetn) begin
      sb_ff.watchdog_fired_flag <= 1'b0;
      sb_ff.standby_reset_seen <= 1'b1;
    end else begin
      sb_ff <= nxt_sb;
    end
  end

  // ==========================================================
  // clock enables for the processor and slow domains
  assign cpu_dif.divisor = {2'b00, st_ff.cpu_div};
  assign slow_dif.divisor = st_ff.slow_div;
  pcr_clk_div u_cpu_div (.pclk(pclk), .presetn(presetn), .dif(cpu_dif));
  pcr_clk_div u_slow_div (.pclk(pclk), .presetn(presetn), .dif(slow_dif));
  assign cpu_clk_en = cpu_dif.tick;
  assign slow_clk_en = slow_dif.tick;

  // ==========================================================
  // outputs
  assign blk_sleep_req = st_ff.sleep_en | {5{{32{st_ff.sleep_all}}}};
  assign periph_reset = st_ff.rst_pulse;
  assign main_clk_gate = (st_ff.state == pcr_pkg::PCR_SLEEP);
  assign pll_enable = !(main_clk_gate && st_ff.sleep_mode);
  assign relock_pending = (st_ff.state == pcr_pkg::PCR_RELOCK);
  assign power_ok_out = st_ff.power_ok_drive;
  assign software_system_reset = st_ff.soft_rst;
  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pulse_wr;
    wr && hit_pls[3] && (pwdata != 32'h00000000);
  endsequence
  sequence s_enter;
    $rose(main_clk_gate);
  endsequence
  a_pulse_self_clear: assert property (s_pulse_wr and !st_ff.locked |=>
    periph_reset != '0 ##1 periph_reset == '0)
    else $error("reset pulse did not clear itself");
  a_lock_blocks: assert property (s_pulse_wr and st_ff.locked |=>
    periph_reset == '0)
    else $error("reset pulse issued while locked");
  a_unlock_opens: assert property (wr && paddr == pcr_pkg::OFF_RST_LOCK &&
    pwdata == pcr_pkg::UNLOCK_PAT |=> !st_ff.locked)
    else $error("unlock pattern did not unlock");
  a_irq_clears_all: assert property (cpu_irq_vector |=>
    !st_ff.sleep_all)
    else $error("global sleep survived an interrupt");
  a_global_forces_req: assert property (st_ff.sleep_all |->
    &blk_sleep_req)
    else $error("global sleep did not assert all requests");
  a_entry_needs_idle: assert property (s_enter |->
    $past(cpu_wfi && no_demand))
    else $error("sleep entered with demand or without wfi");
  a_entry_lock_gate: assert property (s_enter and !$past(pll_locked) |->
    $past(st_ff.sleep_imm && st_ff.sleep_mode))
    else $error("unlocked sleep entry without immediate heavy mode");
  a_pll_depth: assert property (main_clk_gate |->
    pll_enable == !st_ff.sleep_mode)
    else $error("pll state does not match sleep depth");
  a_wake_instant: assert property (main_clk_gate && wake_event |=>
    !main_clk_gate)
    else $error("wake did not ungate the clock at once");
  a_relock_bound: assert property (relock_pending |->
    st_ff.relock_cnt < 19'(RELOCK_CYCLES))
    else $error("relock wait overran its bound");
  a_backup_set_wins: assert property (backup_reset_event |=>
    st_ff.backup_seen)
    else $error("backup reset flag lost");
  a_soft_reset_pulse: assert property (wr && paddr == pcr_pkg::OFF_SYS_RST &&
    pwdata[pcr_pkg::SR_SOFT] |=> software_system_reset
    ##1 !software_system_reset)
    else $error("soft reset request is not a single pulse");
endmodule
`default_nettype wire

// ---- core/pcr_div_if.sv ----
// divisor and tick pair between the controller and a clock divider
// assumes both ends run on the same pclk
`timescale 1ns/1ps
`default_nettype none
interface pcr_div_if;
  logic [9:0] divisor;
  logic tick;
  modport ctl (output divisor, input tick);
  modport div (input divisor, output tick);
endinterface
`default_nettype wire

// ---- core/pcr_pkg.sv ----
// power, clock and reset control: shared constants and types
// assumes a 32-bit apb slave on a 100 MHz pclk
package pcr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_SLEEP_CTL = 12'h000;
  localparam logic [11:0] OFF_CPU_CLK = 12'h004;
  localparam logic [11:0] OFF_SLOW_CLK = 12'h008;
  localparam logic [11:0] OFF_OSC_STAT = 12'h00c;
  localparam logic [11:0] OFF_PWR_STAT = 12'h010;
  localparam logic [11:0] OFF_PWR_CTL = 12'h014;
  localparam logic [11:0] OFF_SYS_RST = 12'h018;
  localparam logic [11:0] OFF_SLEEP_REQ = 12'h030;
  localparam logic [11:0] OFF_CLK_DEM = 12'h050;
  localparam logic [11:0] OFF_RST_PULSE = 12'h070;
  localparam logic [11:0] OFF_RST_LOCK = 12'h084;
  localparam int NBANK = 5;
  localparam logic [11:0] BANK_SPAN = 12'h014;
  // ==========================================================
  // field positions
  localparam int SC_IMM = 8;
  localparam int SC_ALL = 3;
  localparam int SC_TEST = 2;
  localparam int SC_MODE = 0;
  localparam int OS_LOCK = 8;
  localparam int PS_LINK_CLK = 11;
  localparam int PS_LF_CLK = 10;
  localparam int PS_WDT = 8;
  localparam int PS_SYS = 6;
  localparam int PS_BACKUP = 5;
  localparam int PS_STBY = 4;
  localparam int PS_PLT = 3;
  localparam int PS_PWRGD = 2;
  localparam int PC_SEL = 8;
  localparam int PC_POWER_OK_OUT = 0;
  localparam int SR_SOFT = 8;
  // ==========================================================
  // reset values and patterns
  localparam logic [7:0] CPU_DIV_RST = 8'h04;
  localparam logic [9:0] SLOW_DIV_RST = 10'h1e0;
  localparam logic [31:0] LOCK_PAT = 32'ha6382d4d;
  localparam logic [31:0] UNLOCK_PAT = 32'ha6382d4c;
  // which clock-demand bits belong to a real block
  localparam logic [NBANK-1:0][31:0] DEMAND_MASK = {NBANK{32'hffffffff}};
  // ==========================================================
  // timing: heavy sleep pll relock bound
  localparam int CLK_MHZ = 100;
  localparam int RELOCK_US = 3000;
  localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
  typedef enum logic [1:0] {
    PCR_RUN = 2'b00,
    PCR_SLEEP = 2'b01,
    PCR_RELOCK = 2'b11
  } pcr_state_t;
endpackage

// ---- testbench/pcr_blk_model.sv ----
// behavioural model of the peripheral blocks facing the control block
// assumes one pclk domain; busy and access come from the bench
`timescale 1ns/1ps
`default_nettype none
module pcr_blk_model #(
  parameter int DLY = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0][31:0] sleep_req,
  input wire logic [4:0][31:0] busy,
  input wire logic access,
  output logic [4:0][31:0] demand
);
  // ==========================================================
  // sleep handshake
  logic [4:0][31:0] done_ff;
  logic [7:0] cnt_ff;
  // busy blocks finish their work for DLY cycles, then stay quiet
  // until the request falls; one shared counter keeps it small
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= '0;
      cnt_ff <= 8'(DLY);
    end else if (cnt_ff == 8'h00) begin
      done_ff <= sleep_req;
      cnt_ff <= 8'(DLY);
    end else begin
      done_ff <= done_ff & sleep_req;
      if (|(sleep_req & ~done_ff)) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
  // a register access always wakes the clock demand of every block
  assign demand = (busy & ~done_ff) | {160{access}};
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the power, clock and reset control block
// assumes pcr_pkg, pcr_div_if, pcr_clk_div and pcr_ctrl compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, stby_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, d;
  logic [4:0][31:0] sreq, dem, prst, busy;
  logic wfi, irq, wake, lock, pll_en, gate, relock, cpu_en, slow_en;
  logic link_s, lf_s, wdt, bak, leg_n, lnk_n, plat_n, pg, pok, ssr, acc;
  int error_cnt, n_compared, cyc, tc, ts;
  pcr_ctrl #(.RELOCK_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn),
    .standby_rail_resetn(stby_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blk_sleep_req(sreq),
    .blk_clk_demand(dem), .periph_reset(prst), .cpu_wfi(wfi),
    .cpu_irq_vector(irq), .wake_event(wake), .pll_locked(lock),
    .pll_enable(pll_en), .main_clk_gate(gate), .relock_pending(relock),
    .cpu_clk_en(cpu_en), .slow_clk_en(slow_en),
    .host_link_clock_seen(link_s), .low_freq_input_seen(lf_s),
    .watchdog_event(wdt), .backup_reset_event(bak), .legacy_reset_n(leg_n),
    .link_platform_reset_n(lnk_n), .platform_reset_n(plat_n),
    .main_power_good(pg), .power_ok_out(pok), .software_system_reset(ssr));
  pcr_blk_model #(.DLY(4)) blk (.pclk(pclk), .presetn(presetn),
    .sleep_req(sreq), .busy(busy), .access(acc), .demand(dem));
  // ==========================================================
  // clock, tick counter and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ceiling well above the thousand or so cycles the tests take
  always @(posedge pclk) begin
    cyc++;
    // separate counts: the slow ticks must not leak into a cpu window
    if (cpu_en === 1'b1) tc++;
    if (slow_en === 1'b1) ts++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ==========================================================
  // bus cycles and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle cycle between transfers keeps each strobe edge clean
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // count divider ticks over eight whole periods
  task automatic div(input logic [11:0] a, input int n, input int e);
    int t0;
    int t1;
    wr(a, 32'(n));
    repeat (2 * n + 4) @(posedge pclk);
    #1 t0 = (a == pcr_pkg::OFF_CPU_CLK) ? tc : ts;
    repeat (8 * (n == 0 ? 5 : n)) @(posedge pclk);
    #1 t1 = (a == pcr_pkg::OFF_CPU_CLK) ? tc : ts;
    chk(32'(t1 - t0), 32'(e));
  endtask
  task automatic wgate(input logic v);
    int i;
    i = 0;
    while (gate !== v && i < 50) begin
      @(posedge pclk);
      #1 i++;
    end
    chk({31'h0, gate}, {31'h0, v});
  endtask
  task automatic pulse_in(input int k);
    @(posedge pclk);
    if (k == 0) wdt <= 1'b1; else if (k == 1) bak <= 1'b1;
    else if (k == 2) irq <= 1'b1; else wake <= 1'b1;
    @(posedge pclk);
    {wdt, bak, irq, wake} <= 4'h0;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, stby_n, psel, penable, pwrite, wfi, irq, wake, lock} = '0;
    {wdt, bak, leg_n, acc} = '0;
    {paddr, pwdata, busy} = '0;
    lnk_n = 1'b1;
    void'($urandom(99017));
    {link_s, lf_s, pg} = 3'($urandom);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    stby_n <= 1'b1;
    rc(pcr_pkg::OFF_SLEEP_CTL, 32'h0);
    rc(pcr_pkg::OFF_CPU_CLK, 32'h4);
    rc(pcr_pkg::OFF_SLOW_CLK, 32'h1e0);
    rc(pcr_pkg::OFF_RST_LOCK, pcr_pkg::LOCK_PAT);
    rc(pcr_pkg::OFF_PWR_CTL, 32'h101);
    rc(pcr_pkg::OFF_OSC_STAT, 32'h0);
    rc(pcr_pkg::OFF_SYS_RST, 32'h0);
    apb(1'b0, pcr_pkg::OFF_PWR_STAT, 32'h0);
    chk(rdat & 32'hdd5c,
        {link_s, lf_s, 6'h05, leg_n, pg, 2'h0});
    rc(12'h01c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // sleep requests per bank, then live clock demand
    for (int b = 0; b < 5; b++) begin
      d = $urandom;
      busy[b] <= $urandom;
      wr(pcr_pkg::OFF_SLEEP_REQ + 12'(4 * b), d);
      rc(pcr_pkg::OFF_SLEEP_REQ + 12'(4 * b), d);
      chk(sreq[b], d);
    end
    repeat (12) @(posedge pclk);
    for (int b = 0; b < 5; b++) rc(pcr_pkg::OFF_CLK_DEM + 12'(4 * b), dem[b]);
    acc <= 1'b1;
    rc(pcr_pkg::OFF_CLK_DEM, 32'hffffffff);
    acc <= 1'b0;
    // reset pulses: dropped while locked, one cycle once unlocked
    wr(pcr_pkg::OFF_RST_PULSE, 32'hffffffff);
    #1 chk(prst[0], 32'h0);
    wr(pcr_pkg::OFF_RST_LOCK, pcr_pkg::UNLOCK_PAT);
    for (int b = 0; b < 5; b++) begin
      d = $urandom | 32'h1;
      wr(pcr_pkg::OFF_RST_PULSE + 12'(4 * b), d);
      #1 chk(prst[b], d);
      @(posedge pclk);
      #1 chk(prst[b], 32'h0);
    end
    rc(pcr_pkg::OFF_RST_PULSE, 32'h0);
    wr(pcr_pkg::OFF_RST_LOCK, pcr_pkg::LOCK_PAT);
    wr(pcr_pkg::OFF_RST_PULSE + 12'h4, 32'hffffffff);
    #1 chk(prst[1], 32'h0);
    // status flags: set, clear by writing one; the watchdog flag survives system reset
    wr(pcr_pkg::OFF_PWR_STAT, 32'h50);
    pulse_in(0);
    pulse_in(1);
    apb(1'b0, pcr_pkg::OFF_PWR_STAT, 32'h0);
    chk(rdat & 32'h170, 32'h120);
    wr(pcr_pkg::OFF_PWR_STAT, 32'h20);
    wr(pcr_pkg::OFF_SYS_RST, 32'h0);
    #1 chk({31'h0, ssr}, 32'h0);
    wr(pcr_pkg::OFF_SYS_RST, 32'h100);
    #1 chk({31'h0, ssr}, 32'h1);
    apb(1'b0, pcr_pkg::OFF_PWR_STAT, 32'h0);
    chk(rdat & 32'h170, 32'h140);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pcr_pkg::OFF_PWR_STAT, 32'h0);
    chk(rdat & 32'h150, 32'h140);
    wr(pcr_pkg::OFF_PWR_STAT, 32'h100);
    rc(pcr_pkg::OFF_PWR_STAT,
       {link_s, lf_s, 4'h1, 2'h0, leg_n, pg, 2'h0});
    // platform reset source and power ok drive
    chk({31'h0, plat_n}, 32'h0);
    wr(pcr_pkg::OFF_PWR_CTL, 32'h0);
    #1 chk({30'h0, plat_n, pok}, 32'h2);
    rc(pcr_pkg::OFF_PWR_STAT,
       {link_s, lf_s, 4'h1, 2'h0, lnk_n, pg, 2'h0});
    // divider rates, including a stopped slow clock
    div(pcr_pkg::OFF_CPU_CLK, 1, 8);
    div(pcr_pkg::OFF_CPU_CLK, 48, 8);
    d = 32'($urandom_range(7, 2));
    div(pcr_pkg::OFF_CPU_CLK, int'(d), 8);
    div(pcr_pkg::OFF_SLOW_CLK, 5, 8);
    div(pcr_pkg::OFF_SLOW_CLK, 0, 0);
    // heavy sleep: held off until lock unless immediate entry is set
    busy <= '1;
    wr(pcr_pkg::OFF_SLEEP_CTL, 32'h9);
    #1 chk(sreq[3], 32'hffffffff);
    wfi <= 1'b1;
    repeat (20) @(posedge pclk);
    #1 chk({31'h0, gate}, 32'h0);
    wr(pcr_pkg::OFF_SLEEP_CTL, 32'h109);
    wgate(1'b1);
    chk({31'h0, pll_en}, 32'h0);
    wfi <= 1'b0;
    pulse_in(3);
    #1 chk({30'h0, gate, relock}, 32'h1);
    repeat (24) @(posedge pclk);
    #1 chk({31'h0, relock}, 32'h0);
    pulse_in(2);
    rc(pcr_pkg::OFF_SLEEP_CTL, 32'h101);
    // light sleep keeps the pll running and wakes with no relock
    lock <= 1'b1;
    wr(pcr_pkg::OFF_SLEEP_CTL, 32'h8);
    wfi <= 1'b1;
    wgate(1'b1);
    chk({31'h0, pll_en}, 32'h1);
    wfi <= 1'b0;
    pulse_in(3);
    #1 chk({30'h0, gate, relock}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
